// >>> design/ssrp_pkg.sv
package ssrp_pkg;
  // timing figures in their own units
  localparam int CLK_NS = 20;
  localparam int TIMEOUT_NS = 17_500_000;
  localparam int FILT_FS_NS = 50;
  localparam int FILT_HS_NS = 10;
  localparam int SCL_FS_NS = 2_500;
  localparam int SCL_HS_NS = 400;
  // derived cycle counts: filters round up, scl quarters round up (slower)
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
  localparam int FILT_FS_CYC = (FILT_FS_NS + CLK_NS - 1) / CLK_NS;
  localparam int FILT_HS_CYC = (FILT_HS_NS + CLK_NS - 1) / CLK_NS;
  localparam int QTR_FS_CYC = (SCL_FS_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int QTR_HS_CYC = (SCL_HS_NS / 4 + CLK_NS - 1) / CLK_NS;
  // slave address, pointer map, field positions and keys
  localparam logic [6:0] ADDR_BASE = 7'h48;
  localparam logic [4:0] MC_HS_TOP = 5'h01;
  localparam logic [7:0] MC_HS = 8'h08;
  localparam logic [7:0] PTR_TEMP_LAST = 8'h08;
  localparam logic [7:0] PTR_BLK_FIRST = 8'h80;
  localparam logic [7:0] PTR_BLK_LAST = 8'h88;
  localparam logic [7:0] PTR_SWRST = 8'h20;
  localparam logic [7:0] PTR_CFG = 8'h30;
  localparam logic [7:0] PTR_LOCK = 8'hC4;
  localparam logic [15:0] CFG_POR = 16'h0F9C;
  localparam int CFG_SD_BIT = 5;
  localparam int SWRST_BIT = 15;
  localparam logic [15:0] KEY_LOCK = 16'h5CA6;
  localparam logic [15:0] KEY_UNLOCK = 16'hEB19;
  localparam int N_TEMP = 9;
  // host command set
  typedef enum logic [1:0] {OP_PTR, OP_WRITE, OP_READ} ssrp_op_type;
endpackage

// >>> design/ssrp_if.sv
`timescale 1ns/1ps
interface ssrp_if;
  logic host_scl_o, host_scl_oe, host_sda_o, host_sda_oe;
  logic dev_sda_o, dev_sda_oe;
  logic scl, sda;
  // open-drain wired-and with pull-ups
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
               (dev_sda_oe ? dev_sda_o : 1'b1);
  modport dev (input scl, sda, output dev_sda_o, dev_sda_oe);
  modport host (input scl, sda,
                output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface

// >>> design/ssrp_dev.sv
`timescale 1ns/1ps
module ssrp_dev #(
  parameter int TIMEOUT_CYC = ssrp_pkg::TIMEOUT_CYC,
  parameter int FILT_FS = ssrp_pkg::FILT_FS_CYC,
  parameter int FILT_HS = ssrp_pkg::FILT_HS_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  ssrp_if.dev bus,
  input wire logic [1:0] i_addr_sel,
  input wire logic [ssrp_pkg::N_TEMP-1:0][15:0] i_temp,
  input wire logic i_conv_done,
  output logic o_conv_run,
  output logic o_conv_abort,
  output logic o_shutdown,
  output logic [15:0] o_cfg,
  output logic o_locked,
  output logic o_hs_mode,
  output logic [7:0] o_ptr
);
  import ssrp_pkg::*;

  typedef enum logic [2:0]
  {ST_IDLE, ST_RX, ST_RXACK, ST_TX, ST_TXACK, ST_SKIP} ssrp_st_type;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_MSB, K_LSB} ssrp_kind_type;
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  function automatic logic ssrp_is_blk(input logic [7:0] p);
    ssrp_is_blk = (p >= PTR_BLK_FIRST) && (p <= PTR_BLK_LAST);
  endfunction

  logic [1:0] s1_q, s2_q, flt_q, prv_q, as1_q, as2_q;
  logic [1:0][3:0] fcnt_q;
  logic [3:0] flen;
  logic scl_f, sda_f, scl_rise, scl_fall, start_ev, stop_ev;
  ssrp_st_type state_q;
  ssrp_kind_type kind_q, kind_nx;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_q, wmsb_q, ptr_q;
  logic [15:0] rdw_q, rd_word, wr_data, cfg_q;
  logic rw_q, acked_q, sda_oe_q, rd_lsb_q, mack_q, ack_w;
  logic hs_q, busy_q, lock_q, run_q, abort_q;
  logic [TW-1:0] tmo_q;
  logic tmo_hit, byte_done, ptr_ld, ptr_adv, wr_commit, swrst_p;
  logic [6:0] my_addr;

  // two-flop synchronisers for lines and address strap
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      s1_q <= 2'b11;
      s2_q <= 2'b11;
      as1_q <= 2'b00;
      as2_q <= 2'b00;
    end
    else if (i_ce)
    begin
      s1_q <= {bus.sda, bus.scl};
      s2_q <= s1_q;
      as1_q <= i_addr_sel;
      as2_q <= as1_q;
    end
  end

  // glitch filter: level must hold flen cycles; shorter in high-speed
  assign flen = hs_q ? 4'(FILT_HS) : 4'(FILT_FS);
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      flt_q <= 2'b11;
      prv_q <= 2'b11;
      fcnt_q <= '0;
    end
    else if (i_ce)
    begin
      prv_q <= flt_q;
      for (int i = 0; i < 2; i++)
      begin
        if (s2_q[i] == flt_q[i])
          fcnt_q[i] <= 4'h0;
        else if (fcnt_q[i] >= flen - 4'h1)
        begin
          flt_q[i] <= s2_q[i];
          fcnt_q[i] <= 4'h0;
        end
        else
          fcnt_q[i] <= fcnt_q[i] + 4'h1;
      end
    end
  end

  // bus conditions from filtered lines
  assign scl_f = flt_q[0];
  assign sda_f = flt_q[1];
  assign scl_rise = scl_f & ~prv_q[0];
  assign scl_fall = ~scl_f & prv_q[0];
  assign start_ev = scl_f & prv_q[0] & prv_q[1] & ~sda_f;
  assign stop_ev = scl_f & prv_q[0] & ~prv_q[1] & sda_f;
  assign my_addr = ADDR_BASE | {5'h00, as2_q};
  assign byte_done = (state_q == ST_RX) && scl_fall && (cnt_q == 4'h8);

  // acknowledge decision for the byte just received
  always_comb
  begin
    unique case (kind_q)
      K_ADDR: ack_w = (sh_q[7:1] == my_addr);
      K_PTR: ack_w = 1'b1;
      default: ack_w = !(lock_q && (ptr_q == PTR_CFG));
    endcase
    unique case (kind_q)
      K_ADDR: kind_nx = K_PTR;
      K_PTR: kind_nx = K_MSB;
      K_MSB: kind_nx = K_LSB;
      default: kind_nx = K_MSB;
    endcase
  end

  // readable word at the current pointer; block range mirrors results
  always_comb
  begin
    if (ptr_q <= PTR_TEMP_LAST || ssrp_is_blk(ptr_q))
      rd_word = i_temp[ptr_q[3:0]];
    else if (ptr_q == PTR_CFG)
      rd_word = cfg_q;
    else
      rd_word = 16'h0000;
  end

  assign wr_data = {wmsb_q, sh_q};
  assign wr_commit = byte_done && (kind_q == K_LSB) && ack_w;
  assign swrst_p = wr_commit && (ptr_q == PTR_SWRST) && wr_data[SWRST_BIT];
  assign ptr_ld = byte_done && (kind_q == K_PTR);
  assign ptr_adv = (state_q == ST_TXACK) && scl_rise && rd_lsb_q &&
                   ssrp_is_blk(ptr_q);
  assign tmo_hit = (tmo_q == TW'(TIMEOUT_CYC - 1));

  // byte-level protocol engine
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      state_q <= ST_IDLE;
      kind_q <= K_ADDR;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      wmsb_q <= 8'h00;
      rdw_q <= 16'h0000;
      rw_q <= 1'b0;
      acked_q <= 1'b0;
      sda_oe_q <= 1'b0;
      rd_lsb_q <= 1'b0;
      mack_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (tmo_hit || stop_ev)
      begin
        state_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else if (start_ev)
      begin
        state_q <= ST_RX;
        kind_q <= K_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
        rd_lsb_q <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          ST_RX:
            if (scl_rise)
            begin
              sh_q <= {sh_q[6:0], sda_f};
              cnt_q <= cnt_q + 4'h1;
            end
            else if (byte_done)
            begin
              state_q <= ST_RXACK;
              sda_oe_q <= ack_w;
              acked_q <= ack_w;
              if (kind_q == K_ADDR)
                rw_q <= sh_q[0];
              if (kind_q == K_MSB)
                wmsb_q <= sh_q;
            end
          ST_RXACK:
            if (scl_fall)
            begin
              cnt_q <= 4'h0;
              sda_oe_q <= 1'b0;
              if (!acked_q)
                state_q <= ST_SKIP;
              else if (kind_q == K_ADDR && rw_q)
              begin
                state_q <= ST_TX;
                rdw_q <= rd_word;
                tx_q <= rd_word[15:8];
                sda_oe_q <= ~rd_word[15];
                rd_lsb_q <= 1'b0;
              end
              else
              begin
                state_q <= ST_RX;
                kind_q <= kind_nx;
              end
            end
          ST_TX:
            if (scl_fall)
            begin
              if (cnt_q == 4'h7)
              begin
                state_q <= ST_TXACK;
                sda_oe_q <= 1'b0;
              end
              else
              begin
                tx_q <= {tx_q[6:0], 1'b0};
                sda_oe_q <= ~tx_q[6];
                cnt_q <= cnt_q + 4'h1;
              end
            end
          ST_TXACK:
            if (scl_rise)
              mack_q <= ~sda_f;
            else if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (!mack_q)
                state_q <= ST_SKIP;
              else if (!rd_lsb_q)
              begin
                state_q <= ST_TX;
                tx_q <= rdw_q[7:0];
                sda_oe_q <= ~rdw_q[7];
                rd_lsb_q <= 1'b1;
              end
              else
              begin
                state_q <= ST_TX;
                rdw_q <= rd_word;
                tx_q <= rd_word[15:8];
                sda_oe_q <= ~rd_word[15];
                rd_lsb_q <= 1'b0;
              end
            end
          ST_IDLE, ST_SKIP: ;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // pointer register with block auto-increment and wrap
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      ptr_q <= 8'h00;
    else if (i_ce)
    begin
      if (swrst_p)
        ptr_q <= 8'h00;
      else if (ptr_ld)
        ptr_q <= sh_q;
      else if (ptr_adv)
        ptr_q <= (ptr_q == PTR_BLK_LAST) ? PTR_BLK_FIRST :
                 ptr_q + 8'h01;
    end
  end

  // bus activity window, stuck-line timeout, high-speed flag
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      busy_q <= 1'b0;
      tmo_q <= '0;
      hs_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (stop_ev || tmo_hit)
        busy_q <= 1'b0;
      else if (start_ev)
        busy_q <= 1'b1;
      if (busy_q && !(scl_f && sda_f) && !tmo_hit)
        tmo_q <= tmo_q + TW'(1);
      else
        tmo_q <= '0;
      if (stop_ev)
        hs_q <= 1'b0;
      else if (byte_done && kind_q == K_ADDR && sh_q[7:3] == MC_HS_TOP)
        hs_q <= 1'b1;
    end
  end

  // configuration and lock registers, software reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      cfg_q <= CFG_POR;
      lock_q <= 1'b1;
    end
    else if (i_ce)
    begin
      if (swrst_p)
      begin
        cfg_q <= CFG_POR;
        lock_q <= 1'b1;
      end
      else if (wr_commit && ptr_q == PTR_CFG)
        cfg_q <= wr_data;
      else if (wr_commit && ptr_q == PTR_LOCK)
      begin
        if (wr_data == KEY_LOCK)
          lock_q <= 1'b1;
        else if (wr_data == KEY_UNLOCK)
          lock_q <= 1'b0;
      end
    end
  end

  // conversion run control: stop at a conversion boundary or on a software reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      run_q <= 1'b1;
      abort_q <= 1'b0;
    end
    else if (i_ce)
    begin
      abort_q <= swrst_p;
      if (!cfg_q[CFG_SD_BIT])
        run_q <= 1'b1;
      else if (i_conv_done || swrst_p)
        run_q <= 1'b0;
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe_q;
  assign o_conv_run = run_q;
  assign o_conv_abort = abort_q;
  assign o_shutdown = ~run_q;
  assign o_cfg = cfg_q;
  assign o_locked = lock_q;
  assign o_hs_mode = hs_q;
  assign o_ptr = ptr_q;
endmodule // ssrp_dev

// >>> design/ssrp_host.sv
`timescale 1ns/1ps
module ssrp_host #(
  parameter int QTR_FS = ssrp_pkg::QTR_FS_CYC,
  parameter int QTR_HS = ssrp_pkg::QTR_HS_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  ssrp_if.host bus,
  input wire logic i_go,
  input wire ssrp_pkg::ssrp_op_type i_op,
  input wire logic i_hs,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_ptr,
  input wire logic [15:0] i_wdata,
  input wire logic [7:0] i_nrd,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rd_byte,
  output logic o_rd_valid
);
  import ssrp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} ssrp_hst_type;
  typedef enum logic [2:0]
  {R_HS, R_ADDR, R_PTR, R_MSB, R_LSB, R_RD} ssrp_role_type;

  ssrp_hst_type st_q;
  ssrp_role_type role_q;
  ssrp_op_type op_q;
  logic [7:0] qcnt_q, sh_q, ptr_q, nrd_q, rd_q;
  logic [15:0] wd_q;
  logic [6:0] addr_q;
  logic [1:0] q_q;
  logic [3:0] b_q;
  logic hsm_q, scl_oe_q, sda_oe_q, nack_q, rdv_q, done_q, s1_q, s2_q, tick;

  // byte the host places on the bus for a given role
  function automatic logic [7:0] ssrp_byte(input ssrp_role_type r,
    input logic [6:0] a, input logic rd, input logic [7:0] p,
    input logic [15:0] w);
    unique case (r)
      R_HS: ssrp_byte = MC_HS;
      R_ADDR: ssrp_byte = {a, rd};
      R_PTR: ssrp_byte = p;
      R_MSB: ssrp_byte = w[15:8];
      R_LSB: ssrp_byte = w[7:0];
      default: ssrp_byte = 8'hFF;
    endcase
  endfunction

  // sda comes back from the shared wire: two flops
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end
    else if (i_ce)
    begin
      s1_q <= bus.sda;
      s2_q <= s1_q;
    end
  end

  // quarter-period divider that paces scl
  assign tick = (qcnt_q == 8'h00);
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
      qcnt_q <= 8'h00;
    else if (i_ce)
    begin
      if (st_q == H_IDLE)
        qcnt_q <= 8'h00;
      else
        qcnt_q <= tick ? (hsm_q ? 8'(QTR_HS - 1) : 8'(QTR_FS - 1)) :
                  qcnt_q - 8'h01;
    end
  end

  // transfer sequencer: start, bytes with ack slot, stop
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      st_q <= H_IDLE;
      role_q <= R_ADDR;
      op_q <= OP_PTR;
      {sh_q, ptr_q, nrd_q, rd_q, wd_q, addr_q} <= '0;
      {q_q, b_q} <= '0;
      {hsm_q, scl_oe_q, sda_oe_q, nack_q, rdv_q, done_q} <= '0;
    end
    else if (i_ce)
    begin
      rdv_q <= 1'b0;
      done_q <= 1'b0;
      if (st_q == H_IDLE)
      begin
        if (i_go)
        begin
          st_q <= H_START;
          role_q <= i_hs ? R_HS : R_ADDR;
          op_q <= i_op;
          {addr_q, ptr_q, wd_q} <= {i_addr, i_ptr, i_wdata};
          nrd_q <= (i_nrd == 8'h00) ? 8'h01 : i_nrd;
          nack_q <= 1'b0;
          q_q <= 2'h0;
        end
      end
      else if (tick)
      begin
        q_q <= q_q + 2'h1;
        unique case (st_q)
          H_START:
            unique case (q_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              default:
              begin
                scl_oe_q <= 1'b1;
                st_q <= H_BIT;
                b_q <= 4'h0;
                sh_q <= ssrp_byte(role_q, addr_q, op_q == OP_READ, ptr_q,
                                  wd_q);
              end
            endcase
          H_BIT:
            unique case (q_q)
              2'h0: sda_oe_q <= (b_q == 4'h8) ?
                    (role_q == R_RD && nrd_q != 8'h01) : ~sh_q[7];
              2'h1: ;
              2'h2: scl_oe_q <= 1'b0;
              default:
              begin
                scl_oe_q <= 1'b1;
                b_q <= b_q + 4'h1;
                if (b_q != 4'h8)
                  sh_q <= {sh_q[6:0], s2_q};
                else
                begin
                  b_q <= 4'h0;
                  if (role_q == R_HS)
                  begin
                    hsm_q <= 1'b1;
                    role_q <= R_ADDR;
                    st_q <= H_START;
                  end
                  else if (role_q == R_RD)
                  begin
                    rd_q <= sh_q;
                    rdv_q <= 1'b1;
                    sh_q <= 8'hFF;
                    nrd_q <= nrd_q - 8'h01;
                    if (nrd_q == 8'h01)
                      st_q <= H_STOP;
                  end
                  else if (s2_q)
                  begin
                    nack_q <= 1'b1;
                    st_q <= H_STOP;
                  end
                  else if (role_q == R_ADDR && op_q == OP_READ)
                  begin
                    role_q <= R_RD;
                    sh_q <= 8'hFF;
                  end
                  else if (role_q == R_LSB ||
                           (role_q == R_PTR && op_q == OP_PTR))
                    st_q <= H_STOP;
                  else
                  begin
                    role_q <= (role_q == R_ADDR) ? R_PTR :
                              (role_q == R_PTR) ? R_MSB : R_LSB;
                    sh_q <= ssrp_byte((role_q == R_ADDR) ? R_PTR :
                      (role_q == R_PTR) ? R_MSB : R_LSB, addr_q, 1'b0,
                      ptr_q, wd_q);
                  end
                end
              end
            endcase
          default:
            unique case (q_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0;
              default:
              begin
                hsm_q <= 1'b0;
                done_q <= 1'b1;
                st_q <= H_IDLE;
              end
            endcase
        endcase
      end
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;
  assign o_busy = (st_q != H_IDLE);
  assign o_done = done_q;
  assign o_nack = nack_q;
  assign o_rd_byte = rd_q;
  assign o_rd_valid = rdv_q;
endmodule // ssrp_host

// >>> testbench/ssrp_chk.sv
`timescale 1ns/1ps
module ssrp_chk
  import ssrp_pkg::*;
#(
  parameter int TIMEOUT_CYC = 2000
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_o,
  input wire logic host_sda_o,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic scl_q, sda_q, act_q, first_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [15:0] hold_q;
  logic rise, start, stop;
  // bus events on the resolved lines
  assign rise = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;
  // line history
  always_ff @(posedge i_clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // bit position and first byte of a frame
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      cnt_q <= 4'h0;
      first_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= 4'h0;
      first_q <= 1'b1;
    end
    else if (rise && cnt_q == 4'h8)
    begin
      cnt_q <= 4'h0;
      first_q <= 1'b0;
    end
    else if (rise)
    begin
      cnt_q <= cnt_q + 4'h1;
      sh_q <= {sh_q[6:0], sda};
    end
  end
  // frame open between start and stop
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b || stop)
      act_q <= 1'b0;
    else if (start)
      act_q <= 1'b1;
  end
  // length of one continuous device pull
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b || !dev_sda_oe)
      hold_q <= 16'h0000;
    else
      hold_q <= hold_q + 16'h0001;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  open_drain_a: assert property (!(host_scl_o || host_sda_o || dev_sda_o))
    else $error("a line is driven high");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved sda while scl high");
  ack_hold_a: assert property (rise && dev_sda_oe |->
    dev_sda_oe throughout scl [*4]) else $error("device pull not held");
  ack_slot_a: assert property (first_q && $rose(dev_sda_oe) |->
    cnt_q == 4'h8) else $error("device pulled outside ninth bit");
  hs_noack_a: assert property (rise && first_q && cnt_q == 4'h8 &&
    sh_q[7:3] == MC_HS_TOP |-> sda) else $error("master code acknowledged");
  addr_noack_a: assert property (rise && first_q && cnt_q == 4'h8 &&
    sh_q[7:3] != ADDR_BASE[6:2] |-> sda) else $error("foreign address acked");
  idle_rel_a: assert property (!act_q |-> !dev_sda_oe)
    else $error("device pulls an idle bus");
  hold_limit_a: assert property (int'(hold_q) <= TIMEOUT_CYC + 16)
    else $error("device pull outlasts timeout");
  cover property (rise && first_q && cnt_q == 4'h8 && sh_q[7:3] == MC_HS_TOP);
  cover property (rise && cnt_q == 4'h8 && !sda);
  cover property (stop);
endmodule // ssrp_chk

// >>> testbench/tb_sensor_serial_register_port.sv
`timescale 1ns/1ps
module tb_sensor_serial_register_port;
  import ssrp_pkg::*;
  localparam int TMO = 2000;
  logic i_clk, i_rst_b, go, hs, conv_done, abort_seen, hs_seen, hce;
  ssrp_op_type op;
  logic [1:0] sel;
  logic [6:0] addr;
  logic [7:0] ptr, nrd, dptr, rd_byte;
  logic [15:0] wdata, cfg;
  logic [N_TEMP-1:0][15:0] temp;
  logic conv_run, conv_abort, shutdown, locked, hs_mode;
  logic busy, done, nack, rd_valid;
  logic [7:0] rb [0:7];
  int miscompares, comparisons, j;
  ssrp_if bus_if();
  ssrp_dev #(.TIMEOUT_CYC(TMO)) ssrp_dev_inst (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_ce(1'b1), .bus(bus_if), .i_addr_sel(sel),
    .i_temp(temp), .i_conv_done(conv_done), .o_conv_run(conv_run),
    .o_conv_abort(conv_abort), .o_shutdown(shutdown), .o_cfg(cfg),
    .o_locked(locked), .o_hs_mode(hs_mode), .o_ptr(dptr));
  ssrp_host #(.QTR_FS(16)) ssrp_host_inst (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_ce(hce), .bus(bus_if), .i_go(go), .i_op(op),
    .i_hs(hs), .i_addr(addr), .i_ptr(ptr), .i_wdata(wdata), .i_nrd(nrd),
    .o_busy(busy), .o_done(done), .o_nack(nack), .o_rd_byte(rd_byte),
    .o_rd_valid(rd_valid));
  ssrp_chk #(.TIMEOUT_CYC(TMO)) ssrp_chk_inst (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .scl(bus_if.scl), .sda(bus_if.sda),
    .host_scl_o(bus_if.host_scl_o), .host_sda_o(bus_if.host_sda_o),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe));
  // clock
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // remember short pulses and modes seen
  always @(posedge i_clk)
  begin
    if (conv_abort === 1'b1) abort_seen <= 1'b1;
    if (hs_mode === 1'b1) hs_seen <= 1'b1;
  end
  function automatic logic [15:0] tv(input int k);
    return {8'h10 + 8'(k), 8'hC0 + 8'(k)};
  endfunction
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok)
    begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // one host command, bytes read are kept in rb
  task automatic run(input ssrp_op_type o, input logic [7:0] p,
                     input logic [15:0] w, input logic [7:0] n,
                     input logic h, input logic [6:0] a = ADDR_BASE,
                     input bit frz = 1'b0);
    int i, k;
    @(posedge i_clk);
    op <= o;
    {addr, ptr, wdata, nrd, hs, go} <= {a, p, w, n, h, 1'b1};
    @(posedge i_clk);
    go <= 1'b0;
    // freeze the host with scl low while the device pulls sda
    if (frz)
    begin
      for (i = 0; i < 2000 && bus_if.dev_sda_oe !== 1'b1; i++)
        @(negedge i_clk);
      @(posedge i_clk) hce <= 1'b0;
      repeat (TMO / 2) @(negedge i_clk);
      chk(bus_if.dev_sda_oe === 1'b1, "pull dropped early");
      repeat (TMO / 2 + 20) @(negedge i_clk);
      chk(bus_if.dev_sda_oe === 1'b0, "stuck pull kept");
      @(posedge i_clk) hce <= 1'b1;
    end
    k = 0;
    for (i = 0; i < 20000; i++)
    begin
      @(negedge i_clk);
      if (i == 0) chk(busy === 1'b1, "host not busy");
      if (rd_valid === 1'b1 && k < 8) rb[k++] = rd_byte;
      if (done === 1'b1) break;
    end
    if (i == 20000)
    begin
      miscompares++;
      $display("ERROR %0t command never finished", $time);
      conclude();
    end
  endtask
  task automatic pulse_conv;
    @(posedge i_clk) conv_done <= 1'b1;
    @(posedge i_clk) conv_done <= 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic t_reset;
    repeat (10) @(negedge i_clk);
    chk(cfg === CFG_POR && locked === 1'b1 && dptr === 8'h00 &&
        hs_mode === 1'b0 && conv_run === 1'b1, "reset state");
  endtask
  task automatic t_addr;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_clk) sel <= 2'(k);
      repeat (10) @(posedge i_clk);
      run(OP_PTR, 8'h00, 16'h0000, 8'h01, 1'b0, ADDR_BASE + 7'(k));
      chk(nack === 1'b0, "own address refused");
      run(OP_PTR, 8'h00, 16'h0000, 8'h01, 1'b0, ADDR_BASE + 7'((k+1)%4));
      chk(nack === 1'b1, "foreign address taken");
    end
    @(posedge i_clk) sel <= 2'h0;
    repeat (10) @(posedge i_clk);
  endtask
  task automatic t_read;
    logic [15:0] e;
    e = tv(3);
    run(OP_PTR, 8'h03, 16'h0000, 8'h01, 1'b0);
    run(OP_READ, 8'h00, 16'h0000, 8'h01, 1'b0);
    chk(rb[0] === e[15:8], "one-byte read");
    run(OP_READ, 8'h00, 16'h0000, 8'h02, 1'b0);
    chk({rb[0], rb[1]} === e, "word read");
    chk(dptr === 8'h03, "plain pointer moved");
  endtask
  task automatic t_block;
    run(OP_PTR, 8'h87, 16'h0000, 8'h01, 1'b0);
    run(OP_READ, 8'h00, 16'h0000, 8'h06, 1'b1);
    chk({rb[0], rb[1], rb[2], rb[3], rb[4], rb[5]} ===
        {tv(7), tv(8), tv(0)}, "block read wrap");
    chk(hs_seen === 1'b1 && hs_mode === 1'b0, "fast mode");
    run(OP_READ, 8'h00, 16'h0000, 8'h02, 1'b0);
    chk({rb[0], rb[1]} === tv(1) && dptr === 8'h82, "resume");
  endtask
  task automatic t_lock;
    run(OP_WRITE, PTR_CFG, 16'h0FBC, 8'h01, 1'b0);
    chk(nack === 1'b1 && cfg === CFG_POR, "locked write");
    run(OP_WRITE, PTR_LOCK, KEY_UNLOCK, 8'h01, 1'b0);
    chk(locked === 1'b0, "unlock key");
    run(OP_WRITE, PTR_CFG, 16'h0FBC, 8'h01, 1'b0);
    chk(nack === 1'b0 && cfg === 16'h0FBC, "config write");
    pulse_conv();
    chk(shutdown === 1'b1 && conv_run === 1'b0, "shutdown");
    run(OP_WRITE, PTR_CFG, CFG_POR, 8'h01, 1'b0);
    pulse_conv();
    chk(conv_run === 1'b1, "continuous run");
    run(OP_WRITE, PTR_LOCK, KEY_LOCK, 8'h01, 1'b0);
    chk(locked === 1'b1, "lock key");
  endtask
  task automatic t_swrst;
    run(OP_WRITE, PTR_LOCK, KEY_UNLOCK, 8'h01, 1'b0);
    run(OP_WRITE, PTR_CFG, 16'h0F1C, 8'h01, 1'b0);
    run(OP_WRITE, PTR_SWRST, 16'h8000, 8'h01, 1'b0);
    chk(abort_seen === 1'b1 && cfg === CFG_POR &&
        locked === 1'b1 && dptr === 8'h00, "soft reset");
  endtask
  task automatic t_tmo;
    run(OP_READ, 8'h00, 16'h0000, 8'h02, 1'b0, ADDR_BASE, 1'b1);
    chk(nack === 1'b1, "released ack not seen");
    run(OP_READ, 8'h00, 16'h0000, 8'h02, 1'b0);
    chk({rb[0], rb[1]} === tv(0), "port not recovered");
  endtask
  // main sequence
  initial
  begin
    {i_rst_b, go, hs, conv_done, abort_seen, hs_seen} = 6'h00;
    hce = 1'b1;
    op = OP_PTR;
    {sel, addr, ptr, wdata, nrd} = '0;
    miscompares = 0;
    comparisons = 0;
    for (j = 0; j < N_TEMP; j++) temp[j] = tv(j);
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_addr();
    t_read();
    t_block();
    t_lock();
    t_swrst();
    t_tmo();
    conclude();
  end
endmodule // tb_sensor_serial_register_port
